// ===== two_bit_autocorrelator.v
// Our own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`include "autocorr_consts.vh"

module two_bit_autocorrelator #(
	parameter LAGS  = 129,
	parameter PRE_W = 4,
	parameter CNT_W = 24
) (
	// clock and reset
	input  wire        clk,
	input  wire        rst,
	// digitizer pins
	input  wire        sample_sign,
	input  wire        sample_mag,
	// avalon-mm slave
	input  wire [3:0]  address,
	input  wire        read,
	input  wire        write,
	input  wire [31:0] writedata,
	output reg  [31:0] readdata,
	output reg         waitrequest
);

	localparam WORDS  = LAGS + 4;
	localparam DLY1_W = 2 * (LAGS - 1);
	localparam DLY2_W = 4 * (LAGS - 1);

	// ****************************************
	// reset values
	// ****************************************
	localparam [1:0] CTL_RST = `CONTROL_RESET;

	// ****************************************
	// functions
	// ****************************************
	// state code to row/column order: sp, wp, wn, sn
	function [1:0] state_order;
		input [1:0] code;
		begin
			case (code)
				`CODE_STRONG_POS: state_order = 2'h0;
				`CODE_WEAK_POS:   state_order = 2'h1;
				`CODE_WEAK_NEG:   state_order = 2'h2;
				default:          state_order = 2'h3;
			endcase
		end
	endfunction

	// mapped product, undelayed row by delayed column
	function [2:0] mapped_product;
		input [1:0] undelayed;
		input [1:0] delayed;
		begin
			case ({state_order(undelayed), state_order(delayed)})
				4'h0: mapped_product = 3'h6;
				4'h1: mapped_product = 3'h4;
				4'h2: mapped_product = 3'h2;
				4'h3: mapped_product = 3'h0;
				4'h4: mapped_product = 3'h4;
				4'h5: mapped_product = 3'h3;
				4'h6: mapped_product = 3'h3;
				4'h7: mapped_product = 3'h2;
				4'h8: mapped_product = 3'h2;
				4'h9: mapped_product = 3'h3;
				4'ha: mapped_product = 3'h3;
				4'hb: mapped_product = 3'h4;
				4'hc: mapped_product = 3'h0;
				4'hd: mapped_product = 3'h2;
				4'he: mapped_product = 3'h4;
				default: mapped_product = 3'h6;
			endcase
		end
	endfunction

	// accepted bus transfer at one offset
	function bus_hit;
		input [3:0] addr;
		input [3:0] ofs;
		input       taken;
		begin
			bus_hit = taken && (addr == ofs);
		end
	endfunction

	// ****************************************
	// pin synchroniser
	// ****************************************
	reg [1:0] pin_meta_r;
	reg [1:0] sample_r;

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_meta_r <= 2'h0;
			sample_r   <= 2'h0;
		end else begin
			pin_meta_r <= {sample_sign, sample_mag};
			sample_r   <= pin_meta_r;
		end
	end

	// ****************************************
	// delay lines
	// ****************************************
	reg  [DLY1_W-1:0]   dly1_r;
	reg  [DLY2_W-1:0]   dly2_r;
	wire [2*LAGS-1:0]   tap1;
	wire [2*LAGS-1:0]   tap2;

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			dly1_r <= {DLY1_W{1'b0}};
			dly2_r <= {DLY2_W{1'b0}};
		end else begin
			dly1_r <= {dly1_r[DLY1_W-3:0], sample_r};
			dly2_r <= {dly2_r[DLY2_W-3:0], sample_r};
		end
	end

	assign tap1[1:0] = sample_r;
	assign tap2[1:0] = sample_r;

	genvar g;
	generate
		for (g = 1; g < LAGS; g = g + 1) begin : taps
			assign tap1[2*g+1:2*g] = dly1_r[2*g-1:2*g-2];
			assign tap2[2*g+1:2*g] = dly2_r[4*g-1:4*g-2];
		end
	endgenerate

	// ****************************************
	// control and command state
	// ****************************************
	reg        enable_r;
	reg        suspend_r;
	wire       run;
	wire       bus_write;
	wire       bus_read;
	wire       clear_cmd;
	wire       capture_cmd;

	assign bus_write   = write & ~waitrequest;
	assign bus_read    = read & ~waitrequest;
	assign run         = enable_r & ~suspend_r;
	assign clear_cmd   = bus_hit(address, `OFS_COMMAND, bus_write) &
		writedata[`CMD_CLEAR_BIT];
	assign capture_cmd = bus_hit(address, `OFS_COMMAND, bus_write) &
		writedata[`CMD_CAPTURE_BIT];

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			enable_r  <= CTL_RST[`CTL_ENABLE_BIT];
			suspend_r <= CTL_RST[`CTL_SUSPEND_BIT];
		end else if (bus_hit(address, `OFS_CONTROL, bus_write)) begin
			enable_r  <= writedata[`CTL_ENABLE_BIT];
			suspend_r <= writedata[`CTL_SUSPEND_BIT];
		end
	end

	// ****************************************
	// lag accumulators and readout buffers
	// ****************************************
	wire [WORDS*CNT_W-1:0] buf_flat;

	generate
		for (g = 0; g < LAGS; g = g + 1) begin : lag
			reg  [PRE_W-1:0] pre_r;
			reg  [CNT_W-1:0] cnt_r;
			reg  [CNT_W-1:0] buf_r;
			wire [PRE_W:0]   sum;

			assign sum = {1'b0, pre_r} + {{(PRE_W-2){1'b0}},
				mapped_product(tap1[2*g+1:2*g], tap2[2*g+1:2*g])};

			always @(posedge clk or posedge rst) begin
				if (rst) begin
					pre_r <= {PRE_W{1'b0}};
					cnt_r <= {CNT_W{1'b0}};
				end else if (clear_cmd) begin
					pre_r <= {PRE_W{1'b0}};
					cnt_r <= {CNT_W{1'b0}};
				end else if (run) begin
					pre_r <= sum[PRE_W-1:0];
					if (sum[PRE_W])
						cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
				end
			end

			always @(posedge clk or posedge rst) begin
				if (rst)
					buf_r <= {CNT_W{1'b0}};
				else if (capture_cmd)
					buf_r <= cnt_r;
			end

			assign buf_flat[g*CNT_W +: CNT_W] = buf_r;
		end
	endgenerate

	// ****************************************
	// state counters
	// ****************************************
	generate
		for (g = 0; g < 4; g = g + 1) begin : state_cnt
			reg [CNT_W-1:0] cnt_r;
			reg [CNT_W-1:0] buf_r;
			wire            tally;

			assign tally = run && (state_order(sample_r) == g);

			always @(posedge clk or posedge rst) begin
				if (rst)
					cnt_r <= {CNT_W{1'b0}};
				else if (clear_cmd)
					cnt_r <= {CNT_W{1'b0}};
				else if (tally)
					cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
			end

			always @(posedge clk or posedge rst) begin
				if (rst)
					buf_r <= {CNT_W{1'b0}};
				else if (capture_cmd)
					buf_r <= cnt_r;
			end

			assign buf_flat[(LAGS+g)*CNT_W +: CNT_W] = buf_r;
		end
	endgenerate

	// ****************************************
	// byte read pointer
	// ****************************************
	reg  [7:0]       rd_word_r;
	reg  [1:0]       rd_sel_r;
	wire [CNT_W-1:0] rd_word_val;
	reg  [7:0]       rd_byte;

	assign rd_word_val = buf_flat[rd_word_r*CNT_W +: CNT_W];

	always @* begin
		case (rd_sel_r)
			2'h0:    rd_byte = rd_word_val[7:0];
			2'h1:    rd_byte = rd_word_val[15:8];
			default: rd_byte = rd_word_val[23:16];
		endcase
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_word_r <= 8'h00;
			rd_sel_r  <= 2'h0;
		end else if (capture_cmd) begin
			rd_word_r <= 8'h00;
			rd_sel_r  <= 2'h0;
		end else if (bus_hit(address, `OFS_READ_DATA, bus_read)) begin
			if (rd_sel_r == 2'h2) begin
				rd_sel_r <= 2'h0;
				if (rd_word_r == WORDS - 1)
					rd_word_r <= 8'h00;
				else
					rd_word_r <= rd_word_r + 8'h01;
			end else begin
				rd_sel_r <= rd_sel_r + 2'h1;
			end
		end
	end

	// ****************************************
	// avalon-mm answer
	// ****************************************
	reg [31:0] rd_mux;

	always @* begin
		rd_mux = 32'h0;
		case (address)
			`OFS_CONTROL: begin
				rd_mux[`CTL_ENABLE_BIT]  = enable_r;
				rd_mux[`CTL_SUSPEND_BIT] = suspend_r;
			end
			`OFS_READ_DATA:
				rd_mux[7:0] = rd_byte;
			`OFS_STATUS: begin
				rd_mux[`STS_WORD_LSB+7:`STS_WORD_LSB] = rd_word_r;
				rd_mux[`STS_SEL_LSB+1:`STS_SEL_LSB]   = rd_sel_r;
				rd_mux[`STS_RUN_BIT]                  = run;
			end
			default:
				rd_mux = 32'h0;
		endcase
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			waitrequest <= `WAIT_RESET;
			readdata    <= 32'h0;
		end else begin
			if ((read || write) && waitrequest)
				waitrequest <= 1'b0;
			else
				waitrequest <= 1'b1;
			if (read && waitrequest)
				readdata <= rd_mux;
		end
	end

endmodule

// ===== autocorr_consts.vh
// What this block does
// - a new two-bit sample is taken on every clock cycle
// - four sample states: strong neg, weak neg, weak pos, strong pos
// - sign bit 1 means negative; magnitude bit 1 means strong
// - conventional weights -n,-1,+1,+n; hardware uses the mapped table
// - two 129-element delay lines, one and two cycles per element
// - unsigned products, n=3, +-1 zeroed, divided by three, offset three
// - every cycle while enabled and not suspended, each lag multiplies paired elements into its counter
// - 4-bit prescaler per lag; its carry increments a 24-bit counter
// - sampling, delay lines, multipliers and prescalers run on one clock
// - readout buffers hold a copy of the whole counter array
// - suspend bit in the control register halts accumulation so counters settle before capture
// - control logic enables, disables and clears the counter array
// - readout is one byte wide; pointer advances after each read of the read-data register
// - four state counters tally samples per digitizer state
`ifndef AUTOCORR_CONSTS_VH
`define AUTOCORR_CONSTS_VH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define OFS_CONTROL      4'h0
`define OFS_COMMAND      4'h4
`define OFS_READ_DATA    4'h8
`define OFS_STATUS       4'hc

// ****************************************
// field positions
// ****************************************
`define CTL_ENABLE_BIT   0
`define CTL_SUSPEND_BIT  1
`define CMD_CLEAR_BIT    0
`define CMD_CAPTURE_BIT  1
`define STS_WORD_LSB     0
`define STS_SEL_LSB      8
`define STS_RUN_BIT      10

// ****************************************
// reset values
// ****************************************
`define CONTROL_RESET    2'h0
`define WAIT_RESET       1'h1

// ****************************************
// sample state codes {sign, magnitude}
// ****************************************
`define CODE_STRONG_POS  2'h1
`define CODE_WEAK_POS    2'h0
`define CODE_WEAK_NEG    2'h2
`define CODE_STRONG_NEG  2'h3

`endif

// ===== acorr_properties.sv
`timescale 1ns/1ps
module acorr_props (
	// clock and reset
	input wire        clk,
	input wire        rst,
	// avalon-mm
	input wire [3:0]  address,
	input wire        read,
	input wire        write,
	input wire [31:0] writedata,
	input wire [31:0] readdata,
	input wire        waitrequest
);
// ****
// bus checks
// ****
default clocking @(posedge clk); endclocking
default disable iff (rst);
reg [1:0] ctl_r;
always @(posedge clk or posedge rst) begin
	if (rst)
		ctl_r <= 2'h0;
	else if (write && !waitrequest && address == 4'h0)
		ctl_r <= writedata[1:0];
end
sequence taken; (read || write) && waitrequest; endsequence
sequence answer; !waitrequest; endsequence
wait_pulse_a: assert property (taken |=> answer)
	else $error("no answer after request");
wait_once_a: assert property (answer |=> waitrequest)
	else $error("wait low too long");
ack_cause_a: assert property ($fell(waitrequest) |-> $past(read || write))
	else $error("answer without request");
rdata_hold_a: assert property (!$stable(readdata) |-> !waitrequest && read)
	else $error("read data moved");
byte_wide_a: assert property (read && !waitrequest && address == 4'h8
	|-> readdata[31:8] == 24'h0) else $error("read port not byte wide");
cmd_zero_a: assert property (read && !waitrequest && address == 4'h4
	|-> readdata == 32'h0) else $error("command reads nonzero");
unmap_zero_a: assert property (read && !waitrequest && address[1:0] != 2'h0
	|-> readdata == 32'h0) else $error("unmapped read nonzero");
ctl_back_a: assert property (read && !waitrequest && address == 4'h0
	|-> readdata == {30'h0, ctl_r}) else $error("control readback");
run_flag_a: assert property (read && !waitrequest && address == 4'hc
	|-> readdata[10] == (ctl_r[0] && !ctl_r[1])) else $error("run flag");
endmodule
bind two_bit_autocorrelator acorr_props u_props (.clk(clk), .rst(rst),
	.address(address), .read(read), .write(write), .writedata(writedata),
	.readdata(readdata), .waitrequest(waitrequest));

// ===== avalon_ctrl_model.sv
`timescale 1ns/1ps
module avalon_ctrl_model (
	// clock
	input wire         clk,
	// avalon-mm master
	output reg [3:0]   address,
	output reg         read,
	output reg         write,
	output reg [31:0]  writedata,
	input  wire [31:0] readdata,
	input  wire        waitrequest
);
// ****
// controller
// ****
int cyc = 0;
int acc_cyc = 0;
int sus_cyc = 0;
initial begin
	address = 4'h0;
	read = 1'b0;
	write = 1'b0;
	writedata = 32'h0;
end
always @(posedge clk) cyc <= cyc + 1;
task xfer(input bit w, input [3:0] a, input [31:0] d, output [31:0] q);
	@(posedge clk);
	address <= a;
	read <= !w;
	write <= w;
	writedata <= d;
	do @(posedge clk); while (waitrequest !== 1'b0);
	q = readdata;
	acc_cyc = cyc;
	read <= 1'b0;
	write <= 1'b0;
	writedata <= ~d;
endtask
task restart;
	reg [31:0] q;
	xfer(1, 4'h4, 32'h1, q);
	xfer(1, 4'h0, 32'h1, q);
endtask
task freeze;
	reg [31:0] q;
	xfer(1, 4'h0, 32'h3, q);
	sus_cyc = acc_cyc;
	xfer(1, 4'h4, 32'h2, q);
endtask
task rd_word(output [23:0] wd);
	reg [31:0] q;
	for (int i = 0; i < 3; i++) begin
		xfer(0, 4'h8, 32'h0, q);
		wd[8*i+:8] = q[7:0];
	end
endtask
endmodule

// ===== tb_two_bit_autocorrelator.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
	n_errors++; $display("BAD %s exp %h got %h", n, e, g); end end
module tb_two_bit_autocorrelator;
reg         clk = 1'b0;
reg         rst = 1'b1;
reg         sample_sign = 1'b0;
reg         sample_mag = 1'b0;
reg         ph = 1'b0;
wire [3:0]  address;
wire        read, write, waitrequest;
wire [31:0] writedata, readdata;
int n_errors = 0;
int check_count = 0;
int pa = 0;
int pb = 0;
int s;
// ****
// bench
// ****
two_bit_autocorrelator dut (.clk(clk), .rst(rst),
	.sample_sign(sample_sign), .sample_mag(sample_mag),
	.address(address), .read(read), .write(write), .writedata(writedata),
	.readdata(readdata), .waitrequest(waitrequest));
avalon_ctrl_model m (.clk(clk), .address(address), .read(read),
	.write(write), .writedata(writedata), .readdata(readdata),
	.waitrequest(waitrequest));
always #25 clk = ~clk;
always @(posedge clk) begin
	s = ph ? pb : pa;
	ph <= !ph;
	sample_sign <= s > 1;
	sample_mag <= s == 0 || s == 3;
end
function automatic int prod(input int i, input int j);
	int w[4] = '{3, 1, -1, -3};
	int q;
	q = w[i] * w[j];
	if (q == 1 || q == -1) q = 0;
	return q / 3 + 3;
endfunction
task end_sim;
	$display("checks %0d errors %0d", check_count, n_errors);
	if (n_errors == 0 && check_count > 0)
		$display("SIMULATION PASSED");
	else
		$display("SIMULATION FAILED");
	$finish;
endtask
task t_regs;
	reg [31:0] q;
	m.xfer(0, 4'h0, 32'h0, q); `CHK("ctl_rst", 32'h0, q)
	m.xfer(1, 4'h0, 32'h1, q);
	m.xfer(0, 4'hc, 32'h0, q); `CHK("run", 1'b1, q[10])
	m.xfer(1, 4'h0, 32'h3, q);
	m.xfer(0, 4'h0, 32'h0, q); `CHK("ctl_back", 32'h3, q)
	m.xfer(0, 4'hc, 32'h0, q); `CHK("run_sus", 1'b0, q[10])
	m.xfer(0, 4'h2, 32'h0, q); `CHK("unmapped", 32'h0, q)
	m.xfer(0, 4'h4, 32'h0, q); `CHK("cmd_rd", 32'h0, q)
	m.xfer(1, 4'h0, 32'h0, q);
	$display("test regs done");
endtask
task run(input int a, input int b);
	reg [23:0] wd;
	reg [31:0] q;
	reg [23:0] st;
	int e, n;
	pa = a;
	st = 24'h0;
	pb = b;
	repeat (300) @(posedge clk);
	m.restart;
	e = m.acc_cyc;
	repeat (200) @(posedge clk);
	m.freeze;
	n = m.sus_cyc - e;
	for (int k = 0; k < 133; k++) begin
		m.rd_word(wd);
		if (k < 129)
			`CHK("lag", 24'(n * prod(a, k % 2 ? b : a) / 16), wd)
		else if (a == b)
			`CHK("state", 24'(k - 129 == a ? n : 0), wd)
		else if (k - 129 != a && k - 129 != b)
			`CHK("state_idle", 24'h0, wd)
		else
			st = st + wd;
	end
	if (a != b)
		`CHK("state_sum", 24'(n), st)
	m.xfer(0, 4'h8, 32'h0, q);
	`CHK("wrap", 8'(n * prod(a, a) / 16), q[7:0])
	$display("test run %0d %0d done", a, b);
endtask
task t_clear;
	reg [23:0] wd;
	reg [31:0] q;
	m.xfer(1, 4'h4, 32'h1, q);
	m.xfer(1, 4'h4, 32'h2, q);
	m.xfer(0, 4'hc, 32'h0, q); `CHK("ptr_rst", 32'h0, q)
	m.rd_word(wd); `CHK("cleared", 24'h0, wd)
	m.xfer(0, 4'hc, 32'h0, q); `CHK("ptr_adv", 32'h1, q)
	$display("test clear done");
endtask
initial begin
	repeat (20000) @(posedge clk);
	n_errors++;
	end_sim;
end
initial begin
	repeat (10) @(posedge clk);
	rst <= 1'b0;
	t_regs;
	run(0, 0);
	run(1, 1);
	run(2, 2);
	run(3, 3);
	run(0, 3);
	t_clear;
	end_sim;
end
endmodule
